/* src/flash_cfg_pkg.sv */
// constants, types and command codes for the volatile configuration block
// assumes a serial flash register engine clocked well above the link clock

package flash_cfg_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_READ_CONFIG_TWO = 8'h15;
    localparam logic [7:0] CMD_READ_CONFIG_THREE = 8'h33;
    localparam logic [7:0] CMD_ENTER_QUAD_WIDE = 8'h38;
    localparam logic [7:0] CMD_VOLATILE_WRITE_ENABLE = 8'h50;
    localparam logic [7:0] CMD_READ_ANY_REGISTER = 8'h65;
    localparam logic [7:0] CMD_WRITE_ANY_REGISTER = 8'h71;
    localparam logic [7:0] CMD_SET_BURST_LENGTH = 8'h77;
    localparam logic [7:0] CMD_ENTER_FOUR_BYTE = 8'hb7;
    localparam logic [7:0] CMD_EXIT_FOUR_BYTE = 8'he9;
    localparam logic [7:0] CMD_EXIT_QUAD_WIDE = 8'hf5;

    // ------------------------------------------------------------
    // register addresses for the any-register commands
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_NV_CONFIG_ONE = 32'h0000_0002;
    localparam logic [31:0] ADDR_NV_CONFIG_TWO = 32'h0000_0003;
    localparam logic [31:0] ADDR_NV_CONFIG_THREE = 32'h0000_0004;
    localparam logic [31:0] ADDR_V_CONFIG_ONE = 32'h0080_0002;
    localparam logic [31:0] ADDR_V_CONFIG_TWO = 32'h0080_0003;
    localparam logic [31:0] ADDR_V_CONFIG_THREE = 32'h0080_0004;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int LINE3_RESET_BIT = 7;
    localparam int DRIVE_MSB = 6;
    localparam int DRIVE_LSB = 5;
    localparam int QUAD_WIDE_BIT = 3;
    localparam int PROT_SELECT_BIT = 2;
    localparam int BOOT_ADDR_BIT = 1;
    localparam int CUR_ADDR_BIT = 0;
    localparam int QUAD_ENABLE_BIT = 1;
    localparam int WRAP_DISABLE_BIT = 4;
    localparam logic [7:0] CFG_TWO_WRITE_MASK = 8'he5;
    localparam logic [7:0] NV_CFG_TWO_WRITE_MASK = 8'hee;
    localparam logic [7:0] NV_CFG_ONE_RESET = 8'h00;
    localparam logic [7:0] NV_CFG_TWO_RESET = 8'h60;
    localparam logic [7:0] NV_CFG_THREE_RESET = 8'h78;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] WRR_CFG_ONE_INDEX = 3'h1;
    localparam logic [2:0] WRR_CFG_TWO_INDEX = 3'h2;
    localparam logic [2:0] WRR_CFG_THREE_INDEX = 3'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } spi_pins_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } io_drive_t;

    typedef struct packed {
        logic quad_active;
        logic quad_wide;
        logic quad_reads_ok;
        logic line2_is_wp;
        logic line3_reset_armed;
        logic [1:0] drive_strength;
        logic protection_select;
        logic four_byte_addr;
        logic burst_wrap_on;
    } mode_status_t;

    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_WDATA, PH_RDATA, PH_IGNORE
    } phase_t;

endpackage

/* src/flash_volatile_config_two.sv */
// volatile configuration register two with its serial command engine
// assumes link pins arrive asynchronously; spi mode 0, sclk << i_clk

`timescale 1ns/1ps

// Summary of operation
// - line3 reset enable makes data line three an active-low reset input
// - two-bit drive strength field in bits 6:5, writable, loaded at reset
// - quad-wide bit set: whole frame four bits wide; clear: serial command
// - quad-wide bit forces quad mode; clearing it leaves quad enable alone
// - enter-quad-wide sets, exit-quad-wide clears the quad-wide bit
// - both bits clear: single/dual reads, line two write protect, three reset
// - quad enable only: quad reads allowed, line two data, line three data/reset
// - quad-wide bit set: quad reads, lines two and three carry data
// - protection select: 0 legacy range, 1 individual block locking
// - bit 1 read-only, shows address length applied after reset
// - bit 0 current address length; reset value from nonvolatile bit 1
// - enter-four-byte sets, exit-four-byte clears current address length
// - writing nonvolatile address length also updates the current one
// - read by read-config-two and read-any; written by write commands
// - burst wrap applies to array reads only, never register reads
// - line three reset copies nonvolatile registers into volatile ones; i_reset loads both from reset values
// - register three readable by its command, writable by set-burst
module flash_volatile_config_two (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire flash_cfg_pkg::spi_pins_t i_pins,
    output flash_cfg_pkg::io_drive_t o_io,
    output flash_cfg_pkg::mode_status_t o_mode,
    output logic [7:0] o_volatile_config_two
);
    import flash_cfg_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers: a change counts once stages two and three agree
    // ------------------------------------------------------------
    logic [5:0] sync1_r, sync2_r, sync3_r, stable_r, stable_d_r;
    logic [5:0] stable_nxt;

    always_comb begin
        stable_nxt = (~(sync2_r ^ sync3_r) & sync2_r)
                   | ((sync2_r ^ sync3_r) & stable_r);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1_r <= 6'h3f;
            sync2_r <= 6'h3f;
            sync3_r <= 6'h3f;
            stable_r <= 6'h3f;
            stable_d_r <= 6'h3f;
        end else begin
            sync1_r <= i_pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= stable_nxt;
            stable_d_r <= stable_r;
        end
    end

    logic cs_n, sclk_rise, sclk_fall, cs_rise;
    logic [3:0] io_in;
    assign cs_n = stable_r[5];
    assign io_in = stable_r[3:0];
    assign sclk_rise = stable_r[4] & ~stable_d_r[4] & ~cs_n;
    assign sclk_fall = ~stable_r[4] & stable_d_r[4] & ~cs_n;
    assign cs_rise = cs_n & ~stable_d_r[5];

    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic [7:0] nv_one_r, nv_two_r, nv_three_r;
    logic [7:0] v_one_r, v_two_r, v_three_r;
    logic wel_nv_r, wel_v_r;
    logic quad_active, hw_reset;

    assign quad_active = v_two_r[QUAD_WIDE_BIT] | v_one_r[QUAD_ENABLE_BIT];
    // line three low acts as reset only where it is not carrying data
    assign hw_reset = v_two_r[LINE3_RESET_BIT] & ~io_in[3]
                    & (cs_n | ~quad_active);

    function automatic logic [7:0] read_reg(input logic [31:0] addr);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            ADDR_NV_CONFIG_ONE: v = nv_one_r;
            ADDR_NV_CONFIG_TWO: v = nv_two_r;
            ADDR_NV_CONFIG_THREE: v = nv_three_r;
            ADDR_V_CONFIG_ONE: v = v_one_r;
            ADDR_V_CONFIG_TWO: begin
                v = v_two_r & (CFG_TWO_WRITE_MASK | NV_CFG_TWO_WRITE_MASK);
                v[BOOT_ADDR_BIT] = nv_two_r[BOOT_ADDR_BIT];
            end
            ADDR_V_CONFIG_THREE: v = v_three_r;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    phase_t phase_r;
    logic [7:0] cmd_r, sh_r;
    logic [3:0] cnt_r;
    logic [2:0] byte_r;
    logic [31:0] addr_r, rd_addr_r;
    logic wide_r, four_r;
    logic wr_valid_r, wr_wrr_r, hdr_only_r;
    logic [31:0] wr_addr_r;
    logic [7:0] wr_data_r;

    logic [7:0] sh_nxt;
    logic [3:0] cnt_nxt;
    logic byte_done;
    logic [2:0] addr_bytes;

    always_comb begin
        sh_nxt = wide_r ? {sh_r[3:0], io_in} : {sh_r[6:0], io_in[0]};
        cnt_nxt = cnt_r + (wide_r ? 4'h4 : 4'h1);
        byte_done = sclk_rise && (cnt_nxt == BYTE_BITS);
        addr_bytes = four_r ? 3'h4 : 3'h3;
    end

    always_ff @(posedge i_clk) begin
        wr_valid_r <= 1'b0;
        if (i_reset || hw_reset || cs_n) begin
            phase_r <= PH_CMD;
            cnt_r <= 4'h0;
            byte_r <= 3'h0;
            sh_r <= 8'h00;
            addr_r <= 32'h0;
            hdr_only_r <= 1'b0;
            if (cs_n) begin
                wide_r <= v_two_r[QUAD_WIDE_BIT];
                four_r <= v_two_r[CUR_ADDR_BIT];
            end
            if (i_reset) begin
                cmd_r <= 8'h00;
                rd_addr_r <= 32'h0;
                wide_r <= 1'b0;
                four_r <= 1'b0;
                wr_wrr_r <= 1'b0;
                wr_addr_r <= 32'h0;
                wr_data_r <= 8'h00;
            end
        end else if (sclk_rise) begin
            sh_r <= sh_nxt;
            cnt_r <= byte_done ? 4'h0 : cnt_nxt;
            if (byte_done) begin
                unique case (phase_r)
                    PH_CMD: begin
                        cmd_r <= sh_nxt;
                        hdr_only_r <= 1'b1;
                        byte_r <= 3'h0;
                        unique case (sh_nxt)
                            CMD_READ_CONFIG_TWO: begin
                                phase_r <= PH_RDATA;
                                rd_addr_r <= ADDR_V_CONFIG_TWO;
                            end
                            CMD_READ_CONFIG_THREE: begin
                                phase_r <= PH_RDATA;
                                rd_addr_r <= ADDR_V_CONFIG_THREE;
                            end
                            CMD_READ_ANY_REGISTER,
                            CMD_WRITE_ANY_REGISTER: phase_r <= PH_ADDR;
                            CMD_WRITE_REGISTERS,
                            CMD_SET_BURST_LENGTH: phase_r <= PH_WDATA;
                            default: phase_r <= PH_IGNORE;
                        endcase
                    end
                    PH_ADDR: begin
                        addr_r <= {addr_r[23:0], sh_nxt};
                        byte_r <= byte_r + 3'h1;
                        if (byte_r + 3'h1 == addr_bytes) begin
                            byte_r <= 3'h0;
                            if (cmd_r == CMD_READ_ANY_REGISTER) begin
                                phase_r <= PH_RDATA;
                                rd_addr_r <= four_r ? {addr_r[23:0], sh_nxt}
                                           : {8'h00, addr_r[15:0], sh_nxt};
                            end else begin
                                phase_r <= PH_WDATA;
                            end
                        end
                    end
                    PH_WDATA: begin
                        byte_r <= (byte_r == 3'h7) ? byte_r : byte_r + 3'h1;
                        wr_data_r <= sh_nxt;
                        wr_wrr_r <= (cmd_r == CMD_WRITE_REGISTERS);
                        unique case (cmd_r)
                            CMD_WRITE_ANY_REGISTER: begin
                                wr_valid_r <= (byte_r == 3'h0);
                                wr_addr_r <= four_r ? addr_r
                                           : {8'h00, addr_r[23:0]};
                            end
                            CMD_SET_BURST_LENGTH: begin
                                wr_valid_r <= (byte_r == 3'h0);
                                wr_addr_r <= ADDR_V_CONFIG_THREE;
                            end
                            default: begin
                                wr_valid_r <= (byte_r >= WRR_CFG_ONE_INDEX)
                                    && (byte_r <= WRR_CFG_THREE_INDEX);
                                wr_addr_r <= (byte_r == WRR_CFG_ONE_INDEX)
                                    ? ADDR_V_CONFIG_ONE
                                    : (byte_r == WRR_CFG_TWO_INDEX)
                                    ? ADDR_V_CONFIG_TWO : ADDR_V_CONFIG_THREE;
                            end
                        endcase
                    end
                    PH_RDATA, PH_IGNORE: hdr_only_r <= 1'b0;
                endcase
            end else if (phase_r != PH_CMD) begin
                hdr_only_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------
    logic [31:0] wr_target;
    logic [7:0] nv_two_new;
    assign wr_target = (wr_wrr_r && wel_nv_r)
                     ? {8'h00, wr_addr_r[23:0] & 24'h00_00ff}
                     : wr_addr_r;
    assign nv_two_new = wr_data_r & NV_CFG_TWO_WRITE_MASK;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            nv_one_r <= NV_CFG_ONE_RESET;
            nv_two_r <= NV_CFG_TWO_RESET;
            nv_three_r <= NV_CFG_THREE_RESET;
            v_one_r <= NV_CFG_ONE_RESET;
            v_two_r <= NV_CFG_TWO_RESET | {7'h00, NV_CFG_TWO_RESET[1]};
            v_three_r <= NV_CFG_THREE_RESET;
            wel_nv_r <= 1'b0;
            wel_v_r <= 1'b0;
        end else if (hw_reset) begin
            v_one_r <= nv_one_r;
            v_two_r <= {nv_two_r[7:1], nv_two_r[BOOT_ADDR_BIT]};
            v_three_r <= nv_three_r;
            wel_nv_r <= 1'b0;
            wel_v_r <= 1'b0;
        end else begin
            if (cs_rise && hdr_only_r) begin
                unique case (cmd_r)
                    CMD_WRITE_ENABLE: wel_nv_r <= 1'b1;
                    CMD_VOLATILE_WRITE_ENABLE: wel_v_r <= 1'b1;
                    CMD_ENTER_FOUR_BYTE: v_two_r[CUR_ADDR_BIT] <= 1'b1;
                    CMD_EXIT_FOUR_BYTE: v_two_r[CUR_ADDR_BIT] <= 1'b0;
                    CMD_ENTER_QUAD_WIDE: v_two_r[QUAD_WIDE_BIT] <= 1'b1;
                    CMD_EXIT_QUAD_WIDE: v_two_r[QUAD_WIDE_BIT] <= 1'b0;
                    default: ;
                endcase
            end
            if (cs_rise && (cmd_r == CMD_WRITE_REGISTERS
                         || cmd_r == CMD_WRITE_ANY_REGISTER)) begin
                wel_nv_r <= 1'b0;
                wel_v_r <= 1'b0;
            end
            if (wr_valid_r && (wel_nv_r || wel_v_r
                               || wr_addr_r == ADDR_V_CONFIG_THREE
                                  && !wr_wrr_r)) begin
                unique case (wr_target)
                    ADDR_V_CONFIG_ONE: v_one_r <= wr_data_r;
                    ADDR_V_CONFIG_TWO:
                        v_two_r <= wr_data_r & CFG_TWO_WRITE_MASK;
                    ADDR_V_CONFIG_THREE: v_three_r <= wr_data_r;
                    ADDR_NV_CONFIG_ONE: begin
                        nv_one_r <= wr_data_r;
                        v_one_r <= wr_data_r;
                    end
                    ADDR_NV_CONFIG_TWO: begin
                        nv_two_r <= nv_two_new;
                        v_two_r[CUR_ADDR_BIT] <= nv_two_new[BOOT_ADDR_BIT];
                        if (wr_wrr_r)
                            v_two_r <= {nv_two_new[7:1], nv_two_new[1]};
                    end
                    ADDR_NV_CONFIG_THREE: begin
                        nv_three_r <= wr_data_r;
                        v_three_r <= wr_data_r;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // read data onto the data lines, changed on falling sclk
    // ------------------------------------------------------------
    logic [7:0] out_sh_r, out_src;
    logic [2:0] out_cnt_r;
    // register reads repeat the same byte; burst wrap is never applied here
    always_comb out_src = (out_cnt_r == 3'h0) ? read_reg(rd_addr_r)
                                              : out_sh_r;

    always_ff @(posedge i_clk) begin
        if (i_reset || cs_n || phase_r != PH_RDATA) begin
            out_sh_r <= 8'h00;
            out_cnt_r <= 3'h0;
            o_io.out <= 4'h0;
            o_io.oe_n <= 4'hf;
        end else if (sclk_fall) begin
            if (wide_r) begin
                o_io.out <= out_src[7:4];
                o_io.oe_n <= 4'h0;
                out_sh_r <= {out_src[3:0], 4'h0};
                out_cnt_r <= out_cnt_r + 3'h4;
            end else begin
                o_io.out <= {2'b00, out_src[7], 1'b0};
                o_io.oe_n <= 4'b1101;
                out_sh_r <= {out_src[6:0], 1'b0};
                out_cnt_r <= out_cnt_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // registered mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_mode <= '0;
            o_volatile_config_two <= 8'h00;
        end else begin
            o_mode.quad_active <= quad_active;
            o_mode.quad_wide <= v_two_r[QUAD_WIDE_BIT];
            o_mode.quad_reads_ok <= quad_active;
            o_mode.line2_is_wp <= ~quad_active;
            o_mode.line3_reset_armed <= v_two_r[LINE3_RESET_BIT]
                                      & (cs_n | ~quad_active);
            o_mode.drive_strength <= v_two_r[DRIVE_MSB:DRIVE_LSB];
            o_mode.protection_select <= v_two_r[PROT_SELECT_BIT];
            o_mode.four_byte_addr <= v_two_r[CUR_ADDR_BIT];
            o_mode.burst_wrap_on <= ~v_three_r[WRAP_DISABLE_BIT];
            o_volatile_config_two <= read_reg(ADDR_V_CONFIG_TWO);
        end
    end

endmodule

/* bench/flash_volatile_config_two_sva.sv */
// checker for the volatile configuration block
// sees only the top module ports; attached by the bind at the foot
`timescale 1ns/1ps
module flash_volatile_config_two_sva (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire flash_cfg_pkg::spi_pins_t i_pins,
    input wire flash_cfg_pkg::io_drive_t o_io,
    input wire flash_cfg_pkg::mode_status_t o_mode,
    input wire logic [7:0] o_volatile_config_two
);
    import flash_cfg_pkg::*;
    logic [7:0] q1_r;
    logic [7:0] q2_r;
    logic [1:0] rst_r;
    logic calm;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // register value unchanged over three samples, well clear of reset
    always_ff @(posedge i_clk) begin
        q1_r <= o_volatile_config_two;
        q2_r <= q1_r;
        rst_r <= {rst_r[0], i_reset};
    end
    assign calm = (o_volatile_config_two == q1_r) && (q1_r == q2_r)
        && (rst_r == 2'b00);
    sequence s_cs_idle;
        i_pins.cs_n [*6];
    endsequence
    sequence s_quad;
        o_mode.quad_wide;
    endsequence
    property p_reserved;
        !o_volatile_config_two[4];
    endproperty
    property p_drive;
        calm |-> o_mode.drive_strength == o_volatile_config_two[6:5];
    endproperty
    property p_quad_wide;
        calm |-> o_mode.quad_wide == o_volatile_config_two[QUAD_WIDE_BIT];
    endproperty
    property p_quad_force;
        s_quad |-> o_mode.quad_active;
    endproperty
    property p_wp;
        calm |-> o_mode.line2_is_wp == !o_mode.quad_active;
    endproperty
    property p_reads;
        calm |-> o_mode.quad_reads_ok == o_mode.quad_active;
    endproperty
    property p_prot;
        calm |-> o_mode.protection_select == o_volatile_config_two[2];
    endproperty
    property p_addr;
        calm |-> o_mode.four_byte_addr == o_volatile_config_two[0];
    endproperty
    property p_arm;
        calm && o_mode.line3_reset_armed |-> o_volatile_config_two[7];
    endproperty
    property p_release;
        s_cs_idle |-> o_io.oe_n == 4'hf;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");
    a_drive: assert property (p_drive)
        else $error("drive strength differs");
    a_quad_wide: assert property (p_quad_wide)
        else $error("quad wide differs");
    a_quad_force: assert property (p_quad_force)
        else $error("quad mode not forced");
    a_wp: assert property (p_wp)
        else $error("line two role wrong");
    a_reads: assert property (p_reads)
        else $error("quad reads flag wrong");
    a_prot: assert property (p_prot)
        else $error("protection select differs");
    a_addr: assert property (p_addr)
        else $error("address length differs");
    a_arm: assert property (p_arm)
        else $error("line three reset armed while off");
    a_release: assert property (p_release)
        else $error("lines driven while deselected");
endmodule
bind flash_volatile_config_two flash_volatile_config_two_sva chk (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pins(i_pins),
    .o_io(o_io),
    .o_mode(o_mode),
    .o_volatile_config_two(o_volatile_config_two)
);

/* bench/flash_host_model.sv */
// spi host model, mode 0, 125 ns link clock that stops between frames
// assumes a pull-up on every io line the device releases
`timescale 1ns/1ps
module flash_host_model (
    output flash_cfg_pkg::spi_pins_t o_pins,
    input wire flash_cfg_pkg::io_drive_t i_io
);
    import flash_cfg_pkg::*;
    logic cs_n_r = 1'b1;
    logic sclk_r = 1'b0;
    logic [3:0] host_io = 4'hf;
    always_comb begin
        o_pins.cs_n = cs_n_r;
        o_pins.sclk = sclk_r;
        for (int i = 0; i < 4; i++) begin
            o_pins.io[i] = i_io.oe_n[i] ? host_io[i] : i_io.out[i];
        end
    end
    // tx is left aligned; ntx bits sent, then nrx reads (line one, or nibbles)
    task automatic frame(input logic [63:0] tx, input int ntx,
        input int nrx, input bit quad, output logic [7:0] rx);
        rx = 8'h00;
        cs_n_r = 1'b0;
        #62.5;
        for (int i = 0; i < ntx; i += (quad ? 4 : 1)) begin
            if (quad) host_io = tx[63 - i -: 4];
            else host_io[0] = tx[63 - i];
            #62.5 sclk_r = 1'b1;
            #62.5 sclk_r = 1'b0;
        end
        for (int i = 0; i < nrx; i++) begin
            host_io[0] = ~host_io[0];
            #62.5 sclk_r = 1'b1;
            rx = quad ? {rx[3:0], o_pins.io} : {rx[6:0], o_pins.io[1]};
            #62.5 sclk_r = 1'b0;
        end
        #62.5 cs_n_r = 1'b1;
        host_io = 4'hf;
        #200;
    endtask
    // hold line three low while deselected
    task automatic line3_pulse;
        host_io[3] = 1'b0;
        #300 host_io[3] = 1'b1;
        #200;
    endtask
endmodule

/* bench/flash_volatile_config_two_tb_top.sv */
// self-checking bench for the volatile configuration block
// assumes the host model drives the link; clock 100 MHz
`timescale 1ns/1ps
module flash_volatile_config_two_tb_top;
    import flash_cfg_pkg::*;
    logic i_clk;
    logic i_reset;
    spi_pins_t pins;
    io_drive_t io;
    mode_status_t mode;
    logic [7:0] cfg;
    logic [7:0] rx;
    logic [7:0] d;
    logic four;
    int errors;
    int tests_run;
    flash_volatile_config_two uut (.i_clk(i_clk), .i_reset(i_reset),
        .i_pins(pins), .o_io(io), .o_mode(mode),
        .o_volatile_config_two(cfg));
    flash_host_model host (.o_pins(pins), .i_io(io));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c);
        host.frame({c, 56'h0}, 8, 0, 1'b0, rx);
    endtask
    task automatic wr_any(input logic [7:0] en, input logic [23:0] a,
        input logic [7:0] v);
        cmd(en);
        if (four) host.frame({CMD_WRITE_ANY_REGISTER, 8'h00, a, v, 16'h0}, 48,
            0, 1'b0, rx);
        else host.frame({CMD_WRITE_ANY_REGISTER, a, v, 24'h0}, 40, 0, 1'b0,
            rx);
        // track the current address length that the next frame must use
        if (a == ADDR_V_CONFIG_TWO[23:0]) four = v[0];
        if (a == ADDR_NV_CONFIG_TWO[23:0]) four = v[1];
    endtask
    task automatic rd_cfg;
        host.frame({CMD_READ_CONFIG_TWO, 56'h0}, 8, 8, 1'b0, rx);
    endtask
    // readable value after a volatile write
    function automatic logic [7:0] exp_v(input logic [7:0] v,
        input logic nv1);
        return (v & CFG_TWO_WRITE_MASK) | {6'h0, nv1, 1'b0};
    endfunction
    initial begin
        #400000;
        errors++;
        complete_run();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        four = 1'b0;
        i_reset = 1'b1;
        d = $urandom(32'ha0f0);
        repeat (5) @(negedge i_clk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_clk);
        check("reset value", cfg, NV_CFG_TWO_RESET);
        check("drive", mode.drive_strength, NV_CFG_TWO_RESET[6:5]);
        rd_cfg();
        check("read two", rx, NV_CFG_TWO_RESET);
        host.frame({CMD_READ_ANY_REGISTER, ADDR_V_CONFIG_TWO[23:0], 32'h0},
            32, 8, 1'b0, rx);
        check("read any", rx, NV_CFG_TWO_RESET);
        host.frame({CMD_WRITE_ANY_REGISTER, ADDR_V_CONFIG_TWO[23:0], 8'h85,
            24'h0}, 40, 0, 1'b0, rx);
        check("no enable", cfg, NV_CFG_TWO_RESET);
        $display("test defaults done");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hf7 : (i == 1) ? 8'h00 : 8'($urandom) & 8'hf7;
            wr_any(CMD_VOLATILE_WRITE_ENABLE, ADDR_V_CONFIG_TWO[23:0], d);
            check("write any", cfg, exp_v(d, 1'b0));
            rd_cfg();
            check("read back", rx, exp_v(d, 1'b0));
            check("prot", mode.protection_select, d[2]);
            check("addr", mode.four_byte_addr, d[0]);
        end
        cmd(CMD_VOLATILE_WRITE_ENABLE);
        host.frame({CMD_WRITE_REGISTERS, 16'h0, 8'h24, 32'h0}, 32, 0, 1'b0,
            rx);
        four = 1'b0;
        check("write regs", cfg, exp_v(8'h24, 1'b0));
        $display("test writes done");
        cmd(CMD_ENTER_FOUR_BYTE);
        check("four byte", cfg[0], 1'b1);
        cmd(CMD_EXIT_FOUR_BYTE);
        check("three byte", cfg[0], 1'b0);
        cmd(CMD_ENTER_QUAD_WIDE);
        check("quad bit", cfg[3], 1'b1);
        check("quad forced", mode.quad_active, 1'b1);
        check("line two data", mode.line2_is_wp, 1'b0);
        host.frame({CMD_READ_CONFIG_TWO, 56'h0}, 8, 2, 1'b1, rx);
        check("quad read", rx, 8'h2c);
        host.frame({CMD_EXIT_QUAD_WIDE, 56'h0}, 8, 0, 1'b1, rx);
        check("quad exit", mode.quad_wide, 1'b0);
        check("quad off", mode.quad_active, 1'b0);
        check("line two wp", mode.line2_is_wp, 1'b1);
        wr_any(CMD_VOLATILE_WRITE_ENABLE, ADDR_V_CONFIG_ONE[23:0], 8'h02);
        check("quad reads", mode.quad_reads_ok, 1'b1);
        check("quad wide off", mode.quad_wide, 1'b0);
        wr_any(CMD_VOLATILE_WRITE_ENABLE, ADDR_V_CONFIG_ONE[23:0], 8'h00);
        $display("test modes done");
        wr_any(CMD_WRITE_ENABLE, ADDR_NV_CONFIG_TWO[23:0], 8'h62);
        check("nv address", cfg[1:0], 2'b11);
        wr_any(CMD_VOLATILE_WRITE_ENABLE, ADDR_V_CONFIG_TWO[23:0], 8'he0);
        check("read only bit", cfg, exp_v(8'he0, 1'b1));
        check("armed", mode.line3_reset_armed, 1'b1);
        host.line3_pulse();
        check("line three reset", cfg, 8'h63);
        four = 1'b1;
        wr_any(CMD_VOLATILE_WRITE_ENABLE, ADDR_V_CONFIG_TWO[23:0], 8'h04);
        host.line3_pulse();
        check("reset disabled", cfg, exp_v(8'h04, 1'b1));
        $display("test resets done");
        host.frame({CMD_READ_CONFIG_THREE, 56'h0}, 8, 8, 1'b0, rx);
        check("read three", rx, NV_CFG_THREE_RESET);
        check("wrap off", mode.burst_wrap_on, 1'b0);
        host.frame({CMD_SET_BURST_LENGTH, 8'h68, 48'h0}, 16, 0, 1'b0, rx);
        check("wrap on", mode.burst_wrap_on, 1'b1);
        rd_cfg();
        check("register read", rx, exp_v(8'h04, 1'b1));
        $display("test register three done");
        complete_run();
    end
endmodule
